//--- rtl/nv_host_port.sv
// Host-side controller driving the bytewide timekeeping SRAM pins.
// Assumes one 200 MHz clock; the device data pins are split into in/out/enable.
// Requests are single bytes, one at a time; nothing is queued.
// Timing counts come from the shared header; its guard makes a second include harmless
`include "nv_port_params.svh"

module nv_host_port
    import nv_port_pkg::*;
#(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic health_valid,
    output logic backup_health_flag,
    input wire logic supply_ok,
    output logic [ADDR_W-1:0] addr_pin,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic write_strobe_n,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n
);
    port_state_e state_r;
    logic [15:0] cnt_r;
    logic [DATA_W-1:0] dq_sync;
    logic [0:0] supply_sync;

    // Pins from the device are asynchronous to clk
    pin_sync #(.WIDTH(DATA_W)) u_dq_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(dq_in),
        .pin_out(dq_sync)
    );
    pin_sync #(.WIDTH(1)) u_pf_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(supply_ok),
        .pin_out(supply_sync)
    );

    // Counts are small, so the cut to the counter width never loses bits
    function automatic logic [15:0] cyc(input int n);
        return 16'(n);
    endfunction

    // The longer of two phase counts, so one phase can honour two minimums
    function automatic logic [15:0] longer_of(input int a, input int b);
        return (a > b) ? cyc(a) : cyc(b);
    endfunction

    // A request is taken only in idle and only with the supply seen as good
    function automatic logic take_now(input port_state_e st, input logic valid, input logic pwr_ok);
        return (st == ST_IDLE) && valid && pwr_ok;
    endfunction

    // A read is complete once its access wait has run down
    function automatic logic read_done(input port_state_e st, input logic [15:0] cnt);
        return (st == ST_READ) && (cnt == 16'h0000);
    endfunction

    // Sequencer; each phase except the one-cycle write setup holds for its counted cycles.
    // Read: select and enable drop one cycle after the take and stay down for the whole access wait.
    // Write: data goes out first, then select and strobe drop together, so the later falling
    // edge is both of them; the strobe rises before select, so the write ends on the strobe.
    // Every count is rounded up to whole cycles, but the strobe rises a cycle before the pulse count ends, so the write pulse is 27 cycles (135 ns), not 140 ns.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            if (cnt_r != 16'h0000)
                cnt_r <= cnt_r - 16'h0001;
            case (state_r)
                ST_IDLE:
                    // Device ignores access below threshold, so do not start one
                    if (take_now(state_r, req_valid, supply_sync[0]))
                    begin
                        if (req_write)
                        begin
                            state_r <= ST_WSETUP;
                            cnt_r <= cyc(`DATA_SETUP_CYC);
                        end
                        else
                        begin
                            state_r <= ST_READ;
                            cnt_r <= cyc(`READ_WAIT_CYC);
                        end
                    end
                ST_READ:
                    // Hold select and enable until the sample has been taken
                    if (read_done(state_r, cnt_r))
                    begin
                        state_r <= ST_RECOVER;
                        cnt_r <= cyc(`RECOVERY_CYC);
                    end
                ST_WSETUP:
                    begin
                        state_r <= ST_WPULSE;
                        // Pulse covers both write width and data setup
                        cnt_r <= longer_of(`WRITE_PULSE_CYC, `DATA_SETUP_CYC);
                    end
                ST_WPULSE:
                    if (cnt_r == 16'h0000)
                    begin
                        state_r <= ST_WHOLD;
                        cnt_r <= cyc(`DATA_HOLD_CYC);
                    end
                ST_WHOLD:
                    // Data stays driven past the strobe rise; zero hold still gets a cycle of margin
                    if (cnt_r == 16'h0000)
                    begin
                        state_r <= ST_RECOVER;
                        cnt_r <= cyc(`RECOVERY_CYC);
                    end
                ST_RECOVER:
                    // Select stays high here, so the next cycle cannot start inside recovery
                    if (cnt_r == 16'h0000)
                        state_r <= ST_IDLE;
                default:
                    // An illegal code falls back to idle with all pins released
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Pin drive; address latched at start and held to recovery end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            addr_pin <= '0;
            chip_select_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_strobe_n <= 1'b1;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
        end
        else
        begin
            // Address and data load once per request and never move until the next take
            if (take_now(state_r, req_valid, supply_sync[0]))
            begin
                addr_pin <= req_addr;
                dq_out <= req_wdata;
            end
            // Select and enable low, strobe high: read mode
            chip_select_n <= !(state_r == ST_READ || state_r == ST_WPULSE);
            output_enable_n <= !(state_r == ST_READ);
            // Strobe falls with select, rises first, so it frames the write
            write_strobe_n <= !(state_r == ST_WPULSE && cnt_r > 16'h0001);
            // Host drives data only with output enable high, avoiding contention
            dq_oe_n <= !(state_r == ST_WSETUP || state_r == ST_WPULSE || state_r == ST_WHOLD);
        end
    end

    // Response capture; read data taken only after full access time
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            health_valid <= 1'b0;
            backup_health_flag <= 1'b1;
            req_ready <= 1'b0;
        end
        else
        begin
            rsp_valid <= 1'b0;
            // No access before the supply is first seen good; a dip clears nothing held here
            req_ready <= (state_r == ST_IDLE) && supply_sync[0];
            if (read_done(state_r, cnt_r))
            begin
                rsp_valid <= 1'b1;
                rsp_rdata <= dq_sync;
                // Weekday read reports backup source health
                if (addr_pin == ADDR_W'(`WEEKDAY_ADDR))
                begin
                    health_valid <= 1'b1;
                    // A zero flag is passed on untouched so software can distrust the contents
                    backup_health_flag <= dq_sync[`HEALTH_BIT];
                end
            end
        end
    end
endmodule // nv_host_port

//--- rtl/nv_port_params.svh
// Timing constants and field positions for the host port controller.
// Assumes a 200 MHz clock; included by the package and the host port module.
`ifndef NV_PORT_PARAMS_SVH
`define NV_PORT_PARAMS_SVH
`define CLK_PERIOD_PS 5000
// Printed figures in ns (slowest grade, so every grade works)
`define ADDRESS_ACCESS_DELAY_NS 150
`define SELECT_ACCESS_DELAY_NS 150
`define OUTPUT_ENABLE_ACCESS_DELAY_NS 130
`define OUTPUT_HOLD_TIME_NS 5
`define WRITE_RECOVERY_TIME_NS 10
`define DATA_SETUP_TIME_NS 90
`define DATA_HOLD_TIME_NS 0
`define WRITE_DISABLE_DELAY_NS 50
`define WRITE_PULSE_NS 140
// Least times round up to whole cycles, at least one
`define NS_TO_CYC_UP(ns) ((((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
    (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))
// Read sample waits for the later of address and select/enable access, plus two sync stages
`define READ_WAIT_CYC (`NS_TO_CYC_UP(`SELECT_ACCESS_DELAY_NS) + 2)
`define WRITE_PULSE_CYC `NS_TO_CYC_UP(`WRITE_PULSE_NS)
`define DATA_SETUP_CYC `NS_TO_CYC_UP(`DATA_SETUP_TIME_NS)
`define DATA_HOLD_CYC `NS_TO_CYC_UP(`DATA_HOLD_TIME_NS)
`define RECOVERY_CYC `NS_TO_CYC_UP(`WRITE_RECOVERY_TIME_NS)
`define WRITE_DISABLE_CYC `NS_TO_CYC_UP(`WRITE_DISABLE_DELAY_NS)
`define WEEKDAY_ADDR 11'h7fc
`define HEALTH_BIT 7
`endif

//--- rtl/nv_port_pkg.sv
// Types shared by the host port controller.
// Assumes the params header is on the include path.
package nv_port_pkg;
`include "nv_port_params.svh"
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WSETUP,
        ST_WPULSE,
        ST_WHOLD,
        ST_RECOVER
    } port_state_e;
    typedef logic [7:0] byte_t;
endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for a bus of pin inputs.
// Assumes inputs are asynchronous to clk.
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_r <= '0;
            pin_out <= '0;
        end
        else
        begin
            meta_r <= pin_in;
            pin_out <= meta_r;
        end
    end
endmodule // pin_sync

//--- sim/nv_dev_model.sv
// Behavioural timekeeping SRAM at its pins.
// Assumes the host drives the split data bus.
module nv_dev_model (
    input wire logic [10:0] addr_pin,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic supply_ok,
    input wire logic health_good,
    output logic [7:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:2047]; // Kept while supply is low
    logic [7:0] last = 8'h00;
    logic [7:0] rd_w;
    logic armed = 1'b0;
    // Access needs power and the source armed at first power
    wire active = supply_ok && armed;
    wire drv = active && !chip_select_n && !output_enable_n && write_strobe_n;
    // Slow ripple, so an early sample sees stale data
    assign #150 rd_w = (addr_pin == 11'h7fc) ? {health_good, mem[addr_pin][6:0]} : mem[addr_pin];
    always @(posedge supply_ok) armed = 1'b1;
    // Latch at whichever strobe rises first
    always @(posedge write_strobe_n or posedge chip_select_n)
        if (active && (write_strobe_n != chip_select_n))
            mem[addr_pin] = dq_out;
    // A floating bus shows the inverse of its last value
    assign dq_in = drv ? rd_w : (!dq_oe_n ? dq_out : ~last);
    always @(dq_in) if (drv || !dq_oe_n) last = dq_in;
endmodule // nv_dev_model

//--- sim/nv_host_port_properties.sv
// Checker for the host port pins and request side.
// Assumes binding to nv_host_port, one clock.
module nv_port_chk #(
    parameter int ADDR_W = 11,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic supply_ok,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [ADDR_W-1:0] addr_pin,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Strobe low over two edges, the body of a write
    sequence s_wlow;
        !write_strobe_n ##1 !write_strobe_n;
    endsequence
    property p_rd; $fell(output_enable_n) |-> !chip_select_n && write_strobe_n; endproperty
    a_rd: assert property (p_rd) else $error("read enable bad");
    // Sampling early would catch ripple data, not the access
    property p_wait; rsp_valid |-> !output_enable_n && !$past(output_enable_n, 30); endproperty
    a_wait: assert property (p_wait) else $error("early sample");
    property p_oe; !write_strobe_n |-> output_enable_n && !dq_oe_n; endproperty
    a_oe: assert property (p_oe) else $error("contention");
    property p_addr; s_wlow |-> $stable(addr_pin); endproperty
    a_addr: assert property (p_addr) else $error("addr moved");
    property p_data; s_wlow |-> $stable(dq_out); endproperty
    a_data: assert property (p_data) else $error("data moved");
    property p_end; $rose(write_strobe_n) |-> !chip_select_n && !dq_oe_n; endproperty
    a_end: assert property (p_end) else $error("write end");
    property p_start; $fell(write_strobe_n) |-> !chip_select_n ##1 !write_strobe_n [*8]; endproperty
    a_start: assert property (p_start) else $error("write start");
    property p_rec; $rose(chip_select_n) |=> chip_select_n [*2]; endproperty
    a_rec: assert property (p_rec) else $error("no recovery");
    property p_pf; !supply_ok [*4] |-> !req_ready; endproperty
    a_pf: assert property (p_pf) else $error("ready in power fail");
endmodule // nv_port_chk
bind nv_host_port nv_port_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) nv_port_chk_inst (.clk, .reset_n,
    .supply_ok, .req_ready, .rsp_valid, .addr_pin, .chip_select_n, .output_enable_n, .write_strobe_n,
    .dq_out, .dq_oe_n);

//--- sim/tb_top.sv
// Self-checking bench for the host port.
// Assumes the device model on the far pins.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [10:0] req_addr = 11'h000;
    logic [7:0] req_wdata = 8'h00;
    logic supply_ok = 1'b0;
    logic health_good = 1'b1;
    logic req_ready, rsp_valid, health_valid, backup_health_flag, chip_select_n, output_enable_n, write_strobe_n;
    logic dq_oe_n;
    logic [7:0] rsp_rdata, dq_in, dq_out;
    logic [10:0] addr_pin;
    int n_mismatch = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    nv_host_port nv_host_port_inst (.clk, .reset_n, .req_valid, .req_write, .req_addr, .req_wdata, .req_ready,
        .rsp_valid, .rsp_rdata, .health_valid, .backup_health_flag, .supply_ok, .addr_pin, .chip_select_n,
        .output_enable_n, .write_strobe_n, .dq_in, .dq_out, .dq_oe_n);
    nv_dev_model nv_dev_model_inst (.addr_pin, .chip_select_n, .output_enable_n, .write_strobe_n, .dq_out,
        .dq_oe_n, .supply_ok, .health_good, .dq_in);
    task automatic summarize();
        $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait; running out ends the run
    task automatic wait_for(input bit rsp);
        for (int i = 0; i < 400; i++)
        begin
            @(negedge clk);
            if ((rsp ? rsp_valid : req_ready) === 1'b1)
                return;
        end
        n_mismatch++;
        summarize();
    endtask
    // Request held across one rising edge
    task automatic issue(input logic wr, input logic [10:0] a, input logic [7:0] d);
        wait_for(1'b0);
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
    endtask
    task automatic rd(input logic [10:0] a, output logic [7:0] d);
        issue(1'b0, a, 8'h00);
        wait_for(1'b1);
        d = rsp_rdata;
    endtask
    // Both end addresses and 2aa written, read back in reverse
    task automatic t_rw();
        logic [7:0] d;
        logic [10:0] a [3] = '{11'h000, 11'h7ff, 11'h2aa};
        logic [7:0] v [3] = '{8'h00, 8'hff, 8'ha5};
        for (int i = 0; i < 3; i++)
            issue(1'b1, a[i], v[i]);
        for (int i = 2; i >= 0; i--)
        begin
            rd(a[i], d);
            `CHK(d, v[i])
        end
    endtask
    // Flag bit ignores writes and follows the source
    task automatic t_health();
        logic [7:0] d;
        `CHK({health_valid, backup_health_flag}, 2'h1)
        issue(1'b1, 11'h7fc, 8'h00);
        rd(11'h7fc, d);
        @(negedge clk);
        `CHK({health_valid, backup_health_flag, d}, 10'h380)
        health_good = 1'b0;
        rd(11'h7fc, d);
        @(negedge clk);
        `CHK({health_valid, backup_health_flag, d[7]}, 3'h4)
        health_good = 1'b1;
    endtask
    // Supply low refuses requests, data survives
    task automatic t_power();
        logic [7:0] d;
        issue(1'b1, 11'h123, 8'h3c);
        wait_for(1'b0);
        supply_ok = 1'b0;
        repeat (6) @(negedge clk);
        `CHK(req_ready, 1'b0)
        req_valid = 1'b1;
        req_wdata = 8'hc3;
        repeat (40) @(negedge clk);
        `CHK(chip_select_n, 1'b1)
        req_valid = 1'b0;
        supply_ok = 1'b1;
        rd(11'h123, d);
        `CHK(d, 8'h3c)
    endtask
    initial
    begin
        repeat (4) @(negedge clk);
        supply_ok = 1'b1; // First power arms the backup source
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        t_rw();
        t_health();
        t_power();
        summarize();
    end
endmodule // tb_top
